// File: pkg/gisp_cfg.svh
`ifndef GISP_CFG_SVH
`define GISP_CFG_SVH
// How it works
// - open circuit voltage readable, 1.25mV per step
// - status 0x0A: change bit5, low bit4, reset bit0
// - alert pin asserted on low charge
// - master sends address plus direction after start
// - bytes are eight bits msb first, then ack
// - slave answers only to address 0110110
// - write: register select byte, then two data bytes
// - direction one reads, zero writes
// - slave acknowledges accepted address and data bytes
// - slave returns read bytes, master acks or nacks
// - reads use repeated start; stop ends all
// - register write commits only after sixteen bits
// - any status flag set sets config alert bit
// - low flag set below threshold, sticky
// - change and low flags cleared by writing zero
`define GISP_SLAVE_ADDR     7'h36
`define GISP_REG_STATUS     8'h0A
`define GISP_REG_CFG_HI     8'h0C
`define GISP_REG_CFG_LO     8'h0D
`define GISP_REG_OCV_HI     8'h0E
`define GISP_REG_OCV_LO     8'h0F
`define GISP_BIT_CHG        5
`define GISP_BIT_LOW        4
`define GISP_BIT_RI         0
`define GISP_BIT_ALERT      5
`define GISP_STATUS_RST     8'h01
`define GISP_CFG_HI_RST     8'h32
`define GISP_CFG_LO_RST     8'h1C
`define GISP_STATUS_MASK    8'h31
`define GISP_CLK_HZ         100000000
`define GISP_SCL_HZ         100000
`define GISP_HALF_CYC       (`GISP_CLK_HZ / `GISP_SCL_HZ / 2)
`define GISP_WB_CTRL        4'h0
`define GISP_WB_RDATA       4'h8
`define GISP_WB_IRQ_STAT    4'hC
`define GISP_WB_IRQ_MASK    4'h4
`endif

// File: pkg/gisp_pkg.sv
package gisp_pkg;
	typedef enum logic [2:0] {
		DEV_IDLE, DEV_ADDR, DEV_ACK, DEV_RX, DEV_TX, DEV_RXACK
	} gisp_dev_state_t;
	typedef enum logic [3:0] {
		HST_IDLE, HST_START, HST_BIT, HST_ACK, HST_RSTART, HST_STOP, HST_DONE
	} gisp_hst_state_t;
endpackage

// File: pkg/gisp_if.sv
`timescale 1ns/1ps
interface gisp_if;
	logic sclOut, sclOe, sdaHostOut, sdaHostOe, sdaDevOut, sdaDevOe;
	wire  scl = !(sclOe && !sclOut);
	wire  sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));
	logic alertN;
	modport device (input scl, input sda, output sdaDevOut, output sdaDevOe, output alertN);
	modport host (input scl, input sda, output sclOut, output sclOe,
		output sdaHostOut, output sdaHostOe, input alertN);
endinterface

// File: rtl/gisp_device.sv
`timescale 1ns/1ps
`include "gisp_cfg.svh"
module gisp_device (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// two-wire bus
	gisp_if.device           bus,
	// measurement side
	input  wire logic [11:0] ocvCode,
	input  wire logic [7:0]  chargePct,
	input  wire logic        chargeStep
);
	gisp_pkg::gisp_dev_state_t state_r;
	logic [7:0] status_r, cfgHi_r, cfgLo_r, ptr_r, shift_r, hiHold_r;
	logic [3:0] bitCnt_r;
	logic [1:0] byteCnt_r;
	logic       sclQ_r, sdaQ_r, readDir_r, sdaOut_r, sdaOe_r, alertN_r;
	logic       sclRise, sclFall, startCond, stopCond;
	logic [7:0] thresh;
	logic [7:0] rdByte;
	assign sclRise   = bus.scl && !sclQ_r;
	assign sclFall   = !bus.scl && sclQ_r;
	assign startCond = bus.scl && sclQ_r && sdaQ_r && !bus.sda;
	assign stopCond  = bus.scl && sclQ_r && !sdaQ_r && bus.sda;
	// threshold is 32 minus the two's complement field
	assign thresh = 8'h20 - {3'h0, cfgLo_r[4:0]};

	function automatic logic [7:0] regRead(input logic [7:0] a);
		case (a)
			`GISP_REG_STATUS: regRead = status_r;
			`GISP_REG_CFG_HI: regRead = cfgHi_r;
			`GISP_REG_CFG_LO: regRead = cfgLo_r;
			`GISP_REG_OCV_HI: regRead = {4'h0, ocvCode[11:8]};
			`GISP_REG_OCV_LO: regRead = ocvCode[7:0];
			default: regRead = 8'h00;
		endcase
	endfunction

	assign rdByte = regRead(ptr_r);

	always_ff @(posedge core_clk) begin
		sclQ_r <= rst_n ? bus.scl : 1'b1;
		sdaQ_r <= rst_n ? bus.sda : 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= gisp_pkg::DEV_IDLE;
			bitCnt_r <= 4'h0;
			byteCnt_r <= 2'h0;
			shift_r <= 8'h00;
			ptr_r <= 8'h00;
			hiHold_r <= 8'h00;
			readDir_r <= 1'b0;
			sdaOut_r <= 1'b1;
			sdaOe_r <= 1'b0;
		end else if (stopCond) begin
			state_r <= gisp_pkg::DEV_IDLE;
			sdaOe_r <= 1'b0;
		end else if (startCond) begin
			state_r <= gisp_pkg::DEV_ADDR;
			bitCnt_r <= 4'h0;
			sdaOe_r <= 1'b0;
		end else begin
			case (state_r)
				gisp_pkg::DEV_ADDR, gisp_pkg::DEV_RX: begin
					if (sclRise) begin
						shift_r <= {shift_r[6:0], bus.sda};
						bitCnt_r <= bitCnt_r + 4'h1;
					end
					if (sclFall && bitCnt_r == 4'h8) begin
						bitCnt_r <= 4'h0;
						if (state_r == gisp_pkg::DEV_ADDR) begin
							if (shift_r[7:1] == `GISP_SLAVE_ADDR) begin
								readDir_r <= shift_r[0];
								byteCnt_r <= 2'h0;
								sdaOut_r <= 1'b0;
								sdaOe_r <= 1'b1;
								state_r <= gisp_pkg::DEV_ACK;
							end else begin
								state_r <= gisp_pkg::DEV_IDLE;
							end
						end else begin
							if (byteCnt_r == 2'h0) begin
								ptr_r <= shift_r;
							end else if (byteCnt_r == 2'h1) begin
								hiHold_r <= shift_r;
							end else begin
								ptr_r <= ptr_r + 8'h1;
							end
							if (byteCnt_r != 2'h3) begin
								byteCnt_r <= byteCnt_r + 2'h1;
							end
							sdaOut_r <= 1'b0;
							sdaOe_r <= 1'b1;
							state_r <= gisp_pkg::DEV_ACK;
						end
					end
				end
				gisp_pkg::DEV_ACK: begin
					if (sclFall) begin
						if (readDir_r) begin
							// open drain: enable only while the bit is low
							sdaOut_r <= rdByte[7];
							sdaOe_r <= !rdByte[7];
							shift_r <= {rdByte[6:0], 1'b0};
							bitCnt_r <= 4'h1;
							state_r <= gisp_pkg::DEV_TX;
						end else begin
							sdaOe_r <= 1'b0;
							state_r <= gisp_pkg::DEV_RX;
						end
					end
				end
				gisp_pkg::DEV_TX: begin
					if (sclFall) begin
						if (bitCnt_r == 4'h8) begin
							sdaOe_r <= 1'b0;
							ptr_r <= ptr_r + 8'h1;
							state_r <= gisp_pkg::DEV_RXACK;
						end else begin
							sdaOut_r <= shift_r[7];
							sdaOe_r <= !shift_r[7];
							shift_r <= {shift_r[6:0], 1'b0};
							bitCnt_r <= bitCnt_r + 4'h1;
						end
					end
				end
				gisp_pkg::DEV_RXACK: begin
					if (sclRise) begin
						state_r <= bus.sda ? gisp_pkg::DEV_IDLE : gisp_pkg::DEV_ACK;
					end
				end
				default: begin
					sdaOe_r <= 1'b0;
				end
			endcase
		end
	end

	// sixteen bits complete: second data byte shifted in, its ack not yet driven, pointer still at the selected register
	logic wrCommit;
	assign wrCommit = (state_r == gisp_pkg::DEV_RX) && !readDir_r && sclFall
		&& bitCnt_r == 4'h8 && byteCnt_r == 2'h2;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cfgHi_r <= `GISP_CFG_HI_RST;
			cfgLo_r <= `GISP_CFG_LO_RST;
			status_r <= `GISP_STATUS_RST;
		end else begin
			if (wrCommit && ptr_r == `GISP_REG_CFG_HI) begin
				cfgHi_r <= hiHold_r;
				cfgLo_r <= shift_r;
			end
			// set wins over clear
			if (wrCommit && ptr_r == `GISP_REG_STATUS) begin
				status_r <= hiHold_r & `GISP_STATUS_MASK;
			end
			if (chargeStep && cfgLo_r[6]) begin
				status_r[`GISP_BIT_CHG] <= 1'b1;
			end
			if (chargePct < thresh) begin
				status_r[`GISP_BIT_LOW] <= 1'b1;
			end
			if (|status_r) begin
				cfgLo_r[`GISP_BIT_ALERT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		alertN_r <= rst_n ? !status_r[`GISP_BIT_LOW] : 1'b1;
	end

	assign bus.sdaDevOut = sdaOut_r;
	assign bus.sdaDevOe  = sdaOe_r;
	assign bus.alertN    = alertN_r;
endmodule // gisp_device

// File: rtl/gisp_host.sv
`timescale 1ns/1ps
`include "gisp_cfg.svh"
module gisp_host (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// two-wire bus
	gisp_if.host             bus,
	// wishbone slave
	input  wire logic [3:0]  adr_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic             ack_o,
	// interrupt
	output logic             irq
);
	gisp_pkg::gisp_hst_state_t state_r;
	logic [15:0] div_r;
	logic        phase_r, sclOut_r, sdaOut_r, busy_r, rd_r, rdPhase_r;
	logic [7:0]  reg_r, wHi_r, wLo_r, shift_r, rHi_r, rLo_r;
	logic [3:0]  bitCnt_r;
	logic [1:0]  byteIdx_r, irqStat_r, irqMask_r;
	logic        nackSeen_r, ack_r, irq_r, alertQ_r;
	logic [31:0] dat_r;
	logic        tick, wbReq;
	assign tick = div_r == 16'(`GISP_HALF_CYC - 1);
	assign wbReq = cyc_i && stb_i && !ack_r;

	always_ff @(posedge core_clk) begin
		if (!rst_n || tick) div_r <= 16'h0000;
		else div_r <= div_r + 16'h0001;
	end

	function automatic logic [7:0] txByte(input logic [1:0] i, input logic rp);
		if (rp) txByte = {`GISP_SLAVE_ADDR, 1'b1};
		else case (i)
			2'h0: txByte = {`GISP_SLAVE_ADDR, 1'b0};
			2'h1: txByte = reg_r;
			2'h2: txByte = wHi_r;
			default: txByte = wLo_r;
		endcase
	endfunction

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= gisp_pkg::HST_IDLE;
			sclOut_r <= 1'b1; sdaOut_r <= 1'b1; phase_r <= 1'b0;
			busy_r <= 1'b0; rd_r <= 1'b0; rdPhase_r <= 1'b0;
			reg_r <= 8'h00; wHi_r <= 8'h00; wLo_r <= 8'h00;
			shift_r <= 8'h00; rHi_r <= 8'h00; rLo_r <= 8'h00;
			bitCnt_r <= 4'h0; byteIdx_r <= 2'h0; nackSeen_r <= 1'b0;
		end else if (wbReq && we_i && adr_i == `GISP_WB_CTRL && !busy_r) begin
			reg_r <= dat_i[7:0]; wHi_r <= dat_i[15:8]; wLo_r <= dat_i[23:16];
			rd_r <= dat_i[24]; busy_r <= 1'b1; rdPhase_r <= 1'b0;
			byteIdx_r <= 2'h0; nackSeen_r <= 1'b0;
			state_r <= gisp_pkg::HST_START;
		end else if (tick) begin
			case (state_r)
				// scl low first, so the slave lets go of its ack before the restart
				gisp_pkg::HST_RSTART: begin
					sclOut_r <= 1'b0; sdaOut_r <= 1'b1;
					state_r <= gisp_pkg::HST_START;
				end
				gisp_pkg::HST_START: begin
					if (!phase_r) begin sclOut_r <= 1'b1; sdaOut_r <= 1'b1; phase_r <= 1'b1; end
					else begin
						sdaOut_r <= 1'b0; phase_r <= 1'b0;
						shift_r <= txByte(byteIdx_r, rdPhase_r); bitCnt_r <= 4'h0;
						state_r <= gisp_pkg::HST_BIT;
					end
				end
				gisp_pkg::HST_BIT: begin
					if (!phase_r) begin
						sclOut_r <= 1'b0; phase_r <= 1'b1;
						sdaOut_r <= (rdPhase_r && byteIdx_r != 2'h0) ? 1'b1 : shift_r[7];
					end else begin
						sclOut_r <= 1'b1; phase_r <= 1'b0;
						shift_r <= {shift_r[6:0], bus.sda};
						if (bitCnt_r == 4'h7) state_r <= gisp_pkg::HST_ACK;
						bitCnt_r <= bitCnt_r + 4'h1;
					end
				end
				gisp_pkg::HST_ACK: begin
					if (!phase_r) begin
						sclOut_r <= 1'b0; phase_r <= 1'b1;
						// ack first read byte, nack last
						sdaOut_r <= !(rdPhase_r && byteIdx_r == 2'h1);
					end else begin
						sclOut_r <= 1'b1; phase_r <= 1'b0; bitCnt_r <= 4'h0;
						if (rdPhase_r && byteIdx_r == 2'h1) rHi_r <= shift_r;
						if (rdPhase_r && byteIdx_r == 2'h2) rLo_r <= shift_r;
						if (!rdPhase_r && bus.sda) nackSeen_r <= 1'b1;
						byteIdx_r <= byteIdx_r + 2'h1;
						shift_r <= txByte(byteIdx_r + 2'h1, 1'b0);
						if (!rdPhase_r && bus.sda) state_r <= gisp_pkg::HST_STOP;
						else if (rdPhase_r && byteIdx_r == 2'h2) state_r <= gisp_pkg::HST_STOP;
						else if (!rdPhase_r && rd_r && byteIdx_r == 2'h1) begin
							rdPhase_r <= 1'b1; byteIdx_r <= 2'h0;
							state_r <= gisp_pkg::HST_RSTART;
						end else if (!rdPhase_r && byteIdx_r == 2'h3) state_r <= gisp_pkg::HST_STOP;
						else state_r <= gisp_pkg::HST_BIT;
					end
				end
				gisp_pkg::HST_STOP: begin
					if (!phase_r) begin sclOut_r <= 1'b0; sdaOut_r <= 1'b0; phase_r <= 1'b1; end
					else begin sclOut_r <= 1'b1; phase_r <= 1'b0; state_r <= gisp_pkg::HST_DONE; end
				end
				gisp_pkg::HST_DONE: begin
					sdaOut_r <= 1'b1; busy_r <= 1'b0; state_r <= gisp_pkg::HST_IDLE;
				end
				default: state_r <= gisp_pkg::HST_IDLE;
			endcase
		end
	end

	// done event and alert-pin event; set wins over write-one clear
	logic doneEv, alertEv;
	assign doneEv  = tick && state_r == gisp_pkg::HST_DONE;
	assign alertEv = !bus.alertN && alertQ_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irqStat_r <= 2'h0; irqMask_r <= 2'h0; alertQ_r <= 1'b1;
			ack_r <= 1'b0; dat_r <= 32'h0000_0000; irq_r <= 1'b0;
		end else begin
			alertQ_r <= bus.alertN;
			ack_r <= wbReq;
			if (wbReq && we_i && adr_i == `GISP_WB_IRQ_STAT && sel_i[0])
				irqStat_r <= (irqStat_r & ~dat_i[1:0]) | {alertEv, doneEv};
			else irqStat_r <= irqStat_r | {alertEv, doneEv};
			if (wbReq && we_i && adr_i == `GISP_WB_IRQ_MASK && sel_i[0]) irqMask_r <= dat_i[1:0];
			case (adr_i)
				`GISP_WB_CTRL: dat_r <= {30'h0, nackSeen_r, busy_r};
				`GISP_WB_IRQ_MASK: dat_r <= {30'h0, irqMask_r};
				`GISP_WB_RDATA: dat_r <= {16'h0, rHi_r, rLo_r};
				`GISP_WB_IRQ_STAT: dat_r <= {30'h0, irqStat_r};
				default: dat_r <= 32'h0000_0000;
			endcase
			irq_r <= |(irqStat_r & irqMask_r);
		end
	end

	assign dat_o = dat_r;
	assign ack_o = ack_r;
	assign irq = irq_r;
	assign bus.sclOut = sclOut_r;
	assign bus.sclOe = !sclOut_r;
	assign bus.sdaHostOut = sdaOut_r;
	assign bus.sdaHostOe = !sdaOut_r;
endmodule // gisp_host

// File: bench/gisp_monitor.sv
`timescale 1ns/1ps
`include "gisp_cfg.svh"
module gisp_monitor (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// two-wire lines and drivers
	input wire logic scl,
	input wire logic sda,
	input wire logic sclOut,
	input wire logic sclOe,
	input wire logic sdaHostOut,
	input wire logic sdaHostOe,
	input wire logic sdaDevOut,
	input wire logic sdaDevOe
);
	logic [7:0] shReg;
	logic [3:0] bitCnt;
	logic [2:0] byteIdx;
	logic       rdDir;
	logic       sclQ;
	logic       sdaQ;
	wire        sclRise   = scl && !sclQ;
	wire        startSeen = scl && sclQ && sdaQ && !sda;
	wire        ackSlot   = sclRise && bitCnt == 4'h8;

	always_ff @(posedge core_clk) begin
		sclQ <= rst_n ? scl : 1'b1;
		sdaQ <= rst_n ? sda : 1'b1;
	end

	// start also restarts the count, so a repeated start lines up again
	always_ff @(posedge core_clk) begin
		if (!rst_n || startSeen) begin
			bitCnt  <= 4'h0;
			byteIdx <= 3'h0;
		end else if (sclRise) begin
			bitCnt  <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
			byteIdx <= (bitCnt == 4'h8) ? byteIdx + 3'h1 : byteIdx;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sclRise && bitCnt != 4'h8)
			shReg <= {shReg[6:0], sda};
		if (ackSlot && byteIdx == 3'h0)
			rdDir <= shReg[0];
	end

	default clocking mon_cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	dev_low_only_a: assert property (sdaDevOe |-> !sdaDevOut)
		else $error("device drives sda high");
	host_addr_a: assert property (ackSlot && byteIdx == 3'h0 |->
		shReg[7:1] == `GISP_SLAVE_ADDR)
		else $error("host sent another slave address");
	host_rd_ack_a: assert property (ackSlot && rdDir && byteIdx != 3'h0 |->
		sdaHostOe == (byteIdx == 3'h1))
		else $error("host ack or nack wrong in read");
	addr_ack_a: assert property (ackSlot && byteIdx == 3'h0 |->
		(shReg[7:1] == `GISP_SLAVE_ADDR) == !sda)
		else $error("address ack does not match address");
	write_ack_a: assert property (ackSlot && byteIdx != 3'h0 && !rdDir |-> !sda)
		else $error("written byte not acknowledged");
	read_release_a: assert property (ackSlot && byteIdx != 3'h0 && rdDir |-> !sdaDevOe)
		else $error("device holds sda in master ack slot");
	dev_hold_a: assert property (scl && $past(scl) |-> $stable(sdaDevOe))
		else $error("device changes sda while scl high");
	start_host_a: assert property (startSeen |-> !sdaDevOe)
		else $error("device drives sda at start");
endmodule // gisp_monitor

// File: bench/gisp_tb.sv
`timescale 1ns/1ps
module gisp_tb;
	logic        core_clk   = 1'b0;
	logic        rst_n      = 1'b0;
	logic [11:0] ocvCode    = 12'hABC;
	logic [7:0]  chargePct  = 8'h32;
	logic        chargeStep = 1'b0;
	logic [3:0]  wbAdr      = 4'h0;
	logic [31:0] wbDatW     = 32'h0;
	logic        wbWe       = 1'b0;
	logic        wbCyc      = 1'b0;
	logic        wbStb      = 1'b0;
	logic [31:0] wbDatR;
	logic        wbAck;
	logic        irq;
	logic [31:0] rdVal;
	int          error_cnt  = 0;
	int          cmp_count  = 0;
	int          cycles     = 0;

	gisp_if gisp_if_inst ();
	gisp_device gisp_device_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(gisp_if_inst),
		.ocvCode(ocvCode), .chargePct(chargePct), .chargeStep(chargeStep));
	gisp_host gisp_host_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(gisp_if_inst),
		.adr_i(wbAdr), .dat_i(wbDatW), .dat_o(wbDatR), .we_i(wbWe), .sel_i(4'hF),
		.cyc_i(wbCyc), .stb_i(wbStb), .ack_o(wbAck), .irq(irq));
	gisp_monitor gisp_monitor_inst (.core_clk(core_clk), .rst_n(rst_n),
		.scl(gisp_if_inst.scl), .sda(gisp_if_inst.sda),
		.sclOut(gisp_if_inst.sclOut), .sclOe(gisp_if_inst.sclOe),
		.sdaHostOut(gisp_if_inst.sdaHostOut), .sdaHostOe(gisp_if_inst.sdaHostOe),
		.sdaDevOut(gisp_if_inst.sdaDevOut), .sdaDevOe(gisp_if_inst.sdaDevOe));

	always #5 core_clk = ~core_clk;

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// one read and one write transfer at 100 kHz need about 90k cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 99000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
		wbAdr  <= a;
		wbWe   <= w;
		wbDatW <= d;
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		do @(posedge core_clk); while (wbAck !== 1'b1);
		rdVal = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe  <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rdChk(input logic [3:0] a, input logic [31:0] exp);
		wb(a, 1'b0, 32'h0);
		chk(rdVal, exp);
	endtask

	// bounded by the cycle ceiling above
	task automatic waitIrq();
		while (irq !== 1'b1) @(posedge core_clk);
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rdChk(4'hC, 32'h0);
		wb(4'h4, 1'b1, 32'h3);
		wb(4'h0, 1'b1, 32'h0100000E);
		waitIrq();
		rdChk(4'h8, 32'h00000ABC);
		rdChk(4'h0, 32'h0);
		rdChk(4'hC, 32'h1);
		wb(4'hC, 1'b1, 32'h1);
		rdChk(4'hC, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// below the default 4 percent threshold; change alert is off at reset
		chargePct  <= 8'h02;
		chargeStep <= 1'b1;
		@(posedge core_clk);
		chargeStep <= 1'b0;
		waitIrq();
		chk({31'h0, gisp_if_inst.alertN}, 32'h0);
		rdChk(4'hC, 32'h2);
		wb(4'hC, 1'b1, 32'h2);
		chargePct <= 8'h32;
		repeat (20) @(posedge core_clk);
		chk({31'h0, gisp_if_inst.alertN}, 32'h0);
		rdChk(4'hC, 32'h0);
		wb(4'h0, 1'b1, 32'h0000000A);
		waitIrq();
		chk({31'h0, gisp_if_inst.alertN}, 32'h1);
		rdChk(4'hC, 32'h1);
		summarize();
	end
endmodule // gisp_tb
